/* File: rtl/enclave_access_checker_consts.svh */
`ifndef ENCLAVE_ACCESS_CHECKER_CONSTS_SVH
`define ENCLAVE_ACCESS_CHECKER_CONSTS_SVH

// widths
`define EAC_ADDR_W        32
`define EAC_SEG_W         64
`define EAC_APB_AW        12
`define EAC_ERR_W         16

// register byte offsets
`define EAC_OFS_CTRL      12'h000
`define EAC_OFS_RANGE_LO  12'h004
`define EAC_OFS_RANGE_HI  12'h008
`define EAC_OFS_STATUS    12'h00C
`define EAC_OFS_FAULTS    12'h010

// control fields
`define EAC_CTRL_CHECK_EN 0
`define EAC_CTRL_ALTER_EN 1
`define EAC_CTRL_RESET    32'h0000_0003
`define EAC_RANGE_RESET   32'h0000_0000

// status fields
`define EAC_ST_KIND_LO    0
`define EAC_ST_KIND_HI    1
`define EAC_ST_ENCL_BIT   2
`define EAC_ST_IN_ENCL    3
`define EAC_ST_SPLIT      4
`define EAC_ST_ALTER      5

// general protection error code
`define EAC_GP_ERR_CODE   16'h0000

`endif

/* File: rtl/enclave_access_checker_pkg.sv */
package enclave_access_checker_pkg;
  `include "enclave_access_checker_consts.svh"

  typedef enum logic [1:0] {
    ORIG_ENCLAVE  = 2'b00,  // instruction executed inside an enclave
    ORIG_EXPLICIT = 2'b01,  // explicit operand of an enclave instruction
    ORIG_IMPLICIT = 2'b10,  // access through a cached physical address
    ORIG_ORDINARY = 2'b11
  } origin_t;

  typedef enum logic [2:0] {
    ACC_FETCH    = 3'b000,
    ACC_READ     = 3'b001,
    ACC_WRITE    = 3'b010,
    ACC_SS_LOAD  = 3'b011,
    ACC_SS_STORE = 3'b100
  } acc_kind_t;

  typedef enum logic [2:0] {
    regular_page_type            = 3'b000,
    thread_control_page_type     = 3'b001,
    trimmed_page_type            = 3'b010,
    control_structure_page_type  = 3'b011,
    version_array_page_type      = 3'b100,
    shadow_stack_first_page_type = 3'b101,
    shadow_stack_rest_page_type  = 3'b110
  } page_type_t;

  typedef enum logic [1:0] {
    FLT_NONE                     = 2'b00,
    FLT_GENERAL_PROTECTION_FAULT = 2'b01,
    FLT_PAGE_FAULT               = 2'b10
  } fault_kind_t;

  typedef struct packed {
    logic                     valid;
    origin_t                  origin;
    acc_kind_t                kind;
    logic [`EAC_ADDR_W-1:0]   lin_addr;
    logic [3:0]               size_m1;     // bytes minus one
    logic                     seg_fault;   // normal segmentation check failed
    logic                     pg_fault;    // paging check failed
    logic                     virt_exit;   // extended paging or interrupt-controller exit
  } access_req_t;

  typedef struct packed {
    logic       is_epc;        // inside part maps to enclave_page_memory
    logic       owner_match;
    logic       addr_match;    // linear address equals the one recorded at allocation
    page_type_t ptype;
    logic       perm_r;
    logic       perm_w;
    logic       perm_x;
    logic       blocked;
    logic       pending;
    logic       modified;
  } page_meta_t;

  typedef struct packed {
    logic                   valid;
    fault_kind_t            fault;
    logic [`EAC_ERR_W-1:0]  err_code;
    logic                   fault_code_enclave_bit;
    logic                   virt_exit;
    logic                   split;       // data access divided at the range edge
    logic                   alter;       // ordinary-origin non-enclave hit on enclave memory
  } check_resp_t;

  typedef struct packed {
    logic                   valid;
    logic                   resume;      // enclave_resume rather than enclave_enter
    logic [3:0]             usable;      // code, data, extra, stack
    logic [4*`EAC_ADDR_W-1:0] bases;
  } enter_req_t;

  typedef struct packed {
    logic [`EAC_SEG_W-1:0] fs;
    logic [`EAC_SEG_W-1:0] gs;
  } fsgs_t;
endpackage

/* File: rtl/segment_swap.sv */
`timescale 1ns/10ps
module segment_swap
  import enclave_access_checker_pkg::*;
(
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire enclave_access_checker_pkg::enter_req_t enter,
  input  wire logic                              leave,
  input  wire logic                              async_leave,
  input  wire enclave_access_checker_pkg::fsgs_t cur_fsgs,
  input  wire enclave_access_checker_pkg::fsgs_t tcs_fsgs,
  input  wire enclave_access_checker_pkg::fsgs_t frame_fsgs,
  output enclave_access_checker_pkg::fsgs_t      load_fsgs,
  output logic                                   load_valid,
  output enclave_access_checker_pkg::fsgs_t      frame_store,
  output logic                                   frame_store_valid,
  output logic                                   enter_gp,
  output logic                                   in_enclave
);
  fsgs_t saved_r;
  logic  base_bad;

  // any usable segment with a non-zero base blocks entry
  always_comb begin
    base_bad = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (enter.usable[i] && (enter.bases[i*`EAC_ADDR_W +: `EAC_ADDR_W] != '0)) begin
        base_bad = 1'b1;
      end
    end
  end

  // entry saves the outside pair, exits hand it back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      saved_r    <= '0;
      in_enclave <= 1'b0;
      enter_gp   <= 1'b0;
      load_valid <= 1'b0;
      load_fsgs  <= '0;
    end else begin
      enter_gp   <= enter.valid && !in_enclave && base_bad;
      load_valid <= 1'b0;
      if (enter.valid && !in_enclave && !base_bad) begin
        saved_r    <= cur_fsgs;
        load_fsgs  <= enter.resume ? frame_fsgs : tcs_fsgs;
        load_valid <= 1'b1;
        in_enclave <= 1'b1;
      end else if ((leave || async_leave) && in_enclave) begin
        load_fsgs  <= saved_r;
        load_valid <= 1'b1;
        in_enclave <= 1'b0;
      end
    end
  end

  // asynchronous leave parks the enclave pair in the save frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_store       <= '0;
      frame_store_valid <= 1'b0;
    end else begin
      frame_store_valid <= async_leave && in_enclave;
      if (async_leave && in_enclave) begin
        frame_store <= cur_fsgs;
      end
    end
  end

  property p_enter_gp;
    @(posedge pclk) disable iff (!presetn)
      (enter.valid && !in_enclave && base_bad) |=> (enter_gp && !in_enclave && !load_valid);
  endproperty
  a_enter_gp: assert property (p_enter_gp) else $error("bad segment base did not fault entry");

  property p_restore;
    @(posedge pclk) disable iff (!presetn)
      (leave && in_enclave && !enter.valid) |=> (load_valid && load_fsgs == $past(saved_r) && !in_enclave);
  endproperty
  a_restore: assert property (p_restore) else $error("exit did not restore saved fs gs");

  property p_frame;
    @(posedge pclk) disable iff (!presetn)
      (async_leave && in_enclave) |=> (frame_store_valid && frame_store == $past(cur_fsgs));
  endproperty
  a_frame: assert property (p_frame) else $error("async leave did not store fs gs");
endmodule // segment_swap

/* File: rtl/enclave_access_checker.sv */
// What this block does
// - in-enclave fetch outside the enclave range gives general protection, code zero
// - in-enclave shadow-stack op outside the range gives general protection, code zero
// - regular, thread, trimmed pages only at their allocation address, else page fault
// - direct access page must belong to the running enclave, else page fault
// - direct write needs page write permission, else page fault
// - direct read needs page read permission on regular pages, else page fault; shadow-stack pages need none
// - direct fetch needs page execute permission, else page fault
// - shadow-stack ops only on shadow-stack page types
// - direct plain writes to shadow-stack page types fault
// - restricted page types fault on direct access
// - blocked, pending or modified pages each fault on direct access
// - permission bits count only on regular pages
// - entry with a usable non-zero segment base gives general protection
// - entry saves outside fs gs and, unless resuming, loads them from the thread structure
// - both exits restore fs gs saved at entry
// - async exit stores fs gs in the save frame; resume reloads them
// - data access across the range edge is split and each part checked
// - fetch across the range edge gives general protection
// - explicit operands take segment, paging and virtualization faults at access
// - ordinary-origin non-enclave hits on enclave memory are altered
// - normal segmentation checks still apply to every access except implicit ones
// - implicit accesses raise no fault or exit
`timescale 1ns/10ps
module enclave_access_checker
  import enclave_access_checker_pkg::*;
(
  input  wire logic                                 pclk,
  input  wire logic                                 presetn,
  // apb slave
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [`EAC_APB_AW-1:0]               paddr,
  input  wire logic [31:0]                          pwdata,
  output logic [31:0]                               prdata,
  output logic                                      pready,
  output logic                                      pslverr,
  // access check
  input  wire enclave_access_checker_pkg::access_req_t req,
  input  wire enclave_access_checker_pkg::page_meta_t  meta,
  output enclave_access_checker_pkg::check_resp_t      resp,
  // entry and exit
  input  wire enclave_access_checker_pkg::enter_req_t  enter,
  input  wire logic                                 leave,
  input  wire logic                                 async_leave,
  input  wire enclave_access_checker_pkg::fsgs_t       cur_fsgs,
  input  wire enclave_access_checker_pkg::fsgs_t       tcs_fsgs,
  input  wire enclave_access_checker_pkg::fsgs_t       frame_fsgs,
  output enclave_access_checker_pkg::fsgs_t            load_fsgs,
  output logic                                      load_valid,
  output enclave_access_checker_pkg::fsgs_t            frame_store,
  output logic                                      frame_store_valid,
  output logic                                      enter_gp,
  output logic                                      in_enclave
);
  import enclave_access_checker_pkg::*;

  logic [31:0]            ctrl_r;
  logic [31:0]            range_lo_r;
  logic [31:0]            range_hi_r;
  logic [31:0]            faults_r;
  logic [5:0]             status_r;
  logic [`EAC_ADDR_W-1:0] end_addr;
  logic                   start_in;
  logic                   end_in;
  logic                   any_in;
  logic                   direct;
  logic                   gp_cond;
  logic                   pf_cond;
  logic                   enc_pf;
  logic                   split;
  logic                   alter;
  logic                   check_en;
  check_resp_t            resp_nxt;
  logic                   apb_access;
  logic                   apb_done;

  // inclusive range compare, used for both ends of an access
  function automatic logic in_range(input logic [`EAC_ADDR_W-1:0] a,
                                    input logic [31:0] lo, input logic [31:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // enclave metadata check on the in-range part; high means page fault
  function automatic logic page_reject(input page_meta_t m, input acc_kind_t k);
    logic reg_pg;
    logic ss_pg;
    logic bad;
    reg_pg = (m.ptype == regular_page_type);
    ss_pg  = (m.ptype == shadow_stack_first_page_type) || (m.ptype == shadow_stack_rest_page_type);
    bad    = !m.is_epc;
    bad    = bad || !m.owner_match;
    if ((reg_pg || m.ptype == thread_control_page_type || m.ptype == trimmed_page_type) && !m.addr_match) begin
      bad = 1'b1;
    end
    if (m.ptype == control_structure_page_type || m.ptype == thread_control_page_type ||
        m.ptype == version_array_page_type || m.ptype == trimmed_page_type) begin
      bad = 1'b1;
    end
    bad = bad || m.blocked || m.pending || m.modified;
    case (k)
      ACC_WRITE:    bad = bad || ss_pg || !(reg_pg && m.perm_w);
      ACC_READ:     bad = bad || !((reg_pg && m.perm_r) || ss_pg);
      ACC_FETCH:    bad = bad || !(reg_pg && m.perm_x);
      ACC_SS_LOAD,
      ACC_SS_STORE: bad = bad || !ss_pg;
      default:      bad = 1'b1;
    endcase
    return bad;
  endfunction

  assign check_en = ctrl_r[`EAC_CTRL_CHECK_EN];
  assign end_addr = req.lin_addr + `EAC_ADDR_W'(req.size_m1);
  assign start_in = in_range(req.lin_addr, range_lo_r, range_hi_r);
  assign end_in   = in_range(end_addr, range_lo_r, range_hi_r);
  assign any_in   = start_in || end_in;
  // a direct access needs the core to be inside an enclave
  assign direct   = (req.origin == ORIG_ENCLAVE) && in_enclave;

  // general protection conditions of one access
  always_comb begin
    gp_cond = 1'b0;
    if (req.origin != ORIG_IMPLICIT) begin
      gp_cond = req.seg_fault;
    end
    if (direct && check_en) begin
      if (req.kind == ACC_FETCH && !(start_in && end_in)) begin
        gp_cond = 1'b1;
      end
      if ((req.kind == ACC_SS_LOAD || req.kind == ACC_SS_STORE) && !(start_in && end_in)) begin
        gp_cond = 1'b1;
      end
    end
  end

  // page fault conditions; the outside part of a split access sees no enclave check
  always_comb begin
    enc_pf  = direct && check_en && any_in && page_reject(meta, req.kind);
    pf_cond = enc_pf || ((req.origin != ORIG_IMPLICIT) && req.pg_fault);
    split   = direct && (start_in != end_in) && (req.kind == ACC_READ || req.kind == ACC_WRITE);
    alter   = !direct && (req.origin == ORIG_ORDINARY) && meta.is_epc && ctrl_r[`EAC_CTRL_ALTER_EN];
  end

  // single verdict per access, protection fault first
  always_comb begin
    resp_nxt       = '0;
    resp_nxt.valid = req.valid;
    resp_nxt.split = req.valid && split;
    if (req.valid) begin
      if (gp_cond) begin
        resp_nxt.fault    = FLT_GENERAL_PROTECTION_FAULT;
        resp_nxt.err_code = `EAC_GP_ERR_CODE;
      end else if (pf_cond) begin
        resp_nxt.fault                  = FLT_PAGE_FAULT;
        resp_nxt.fault_code_enclave_bit = enc_pf;
      end else begin
        resp_nxt.virt_exit = (req.origin == ORIG_EXPLICIT) && req.virt_exit;
        resp_nxt.alter     = alter;
      end
    end
  end

  // verdict register, one cycle after the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp <= '0;
    end else begin
      resp <= resp_nxt;
    end
  end

  // last verdict and running fault count for software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= '0;
      faults_r <= '0;
    end else begin
      if (resp_nxt.valid) begin
        status_r <= {resp_nxt.alter, resp_nxt.split, 1'b0, resp_nxt.fault_code_enclave_bit, resp_nxt.fault};
      end
      // saturate rather than wrap so a storm of faults stays visible
      if (resp_nxt.valid && resp_nxt.fault != FLT_NONE && faults_r != 32'hFFFF_FFFF) begin
        faults_r <= faults_r + 32'h0000_0001;
      end
    end
  end

  segment_swap u_swap (
    .pclk              (pclk),
    .presetn           (presetn),
    .enter             (enter),
    .leave             (leave),
    .async_leave       (async_leave),
    .cur_fsgs          (cur_fsgs),
    .tcs_fsgs          (tcs_fsgs),
    .frame_fsgs        (frame_fsgs),
    .load_fsgs         (load_fsgs),
    .load_valid        (load_valid),
    .frame_store       (frame_store),
    .frame_store_valid (frame_store_valid),
    .enter_gp          (enter_gp),
    .in_enclave        (in_enclave)
  );

  // one wait state: pready is a flop, so each access phase lasts two cycles
  assign apb_access = psel && penable;
  assign apb_done   = apb_access && pready;

  function automatic logic addr_known(input logic [`EAC_APB_AW-1:0] a);
    return (a == `EAC_OFS_CTRL) || (a == `EAC_OFS_RANGE_LO) || (a == `EAC_OFS_RANGE_HI) ||
           (a == `EAC_OFS_STATUS) || (a == `EAC_OFS_FAULTS);
  endfunction

  // apb handshake and read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= apb_access && !pready;
      pslverr <= apb_access && !pready && !addr_known(paddr);
      prdata  <= '0;
      if (apb_access && !pready && !pwrite) begin
        case (paddr)
          `EAC_OFS_CTRL:     prdata <= ctrl_r;
          `EAC_OFS_RANGE_LO: prdata <= range_lo_r;
          `EAC_OFS_RANGE_HI: prdata <= range_hi_r;
          `EAC_OFS_STATUS:   prdata <= {26'h000_0000, status_r[5:4], in_enclave, status_r[2:0]};
          `EAC_OFS_FAULTS:   prdata <= faults_r;
          default:           prdata <= '0;
        endcase
      end
    end
  end

  // register writes land on the completing edge only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r     <= `EAC_CTRL_RESET;
      range_lo_r <= `EAC_RANGE_RESET;
      range_hi_r <= `EAC_RANGE_RESET;
    end else if (apb_done && pwrite) begin
      case (paddr)
        `EAC_OFS_CTRL:     ctrl_r     <= {30'h0000_0000, pwdata[1:0]};
        `EAC_OFS_RANGE_LO: range_lo_r <= pwdata;
        `EAC_OFS_RANGE_HI: range_hi_r <= pwdata;
        default:           ctrl_r     <= ctrl_r;
      endcase
    end
  end

  property p_fetch_out;
    @(posedge pclk) disable iff (!presetn)
      (req.valid && direct && check_en && req.kind == ACC_FETCH && !(start_in && end_in))
        |=> (resp.fault == FLT_GENERAL_PROTECTION_FAULT && resp.err_code == `EAC_GP_ERR_CODE);
  endproperty
  a_fetch_out: assert property (p_fetch_out) else $error("fetch outside range not protected");

  property p_ss_out;
    @(posedge pclk) disable iff (!presetn)
      (req.valid && direct && check_en && req.kind == ACC_SS_STORE && !start_in)
        |=> (resp.fault == FLT_GENERAL_PROTECTION_FAULT);
  endproperty
  a_ss_out: assert property (p_ss_out) else $error("shadow store outside range not protected");

  property p_ss_write;
    @(posedge pclk) disable iff (!presetn)
      (req.valid && direct && check_en && start_in && end_in && !req.seg_fault && req.kind == ACC_WRITE &&
       meta.ptype == shadow_stack_rest_page_type)
        |=> (resp.fault == FLT_PAGE_FAULT && resp.fault_code_enclave_bit);
  endproperty
  a_ss_write: assert property (p_ss_write) else $error("plain write to shadow page allowed");

  property p_blocked;
    @(posedge pclk) disable iff (!presetn)
      (req.valid && direct && check_en && start_in && !gp_cond && (meta.blocked || meta.pending || meta.modified))
        |=> (resp.fault == FLT_PAGE_FAULT && resp.fault_code_enclave_bit);
  endproperty
  a_blocked: assert property (p_blocked) else $error("blocked or pending page allowed");

  property p_implicit;
    @(posedge pclk) disable iff (!presetn)
      (req.valid && req.origin == ORIG_IMPLICIT) |=> (resp.valid && resp.fault == FLT_NONE && !resp.virt_exit);
  endproperty
  a_implicit: assert property (p_implicit) else $error("implicit access faulted");

  property p_seg_first;
    @(posedge pclk) disable iff (!presetn)
      (req.valid && req.origin != ORIG_IMPLICIT && req.seg_fault && req.pg_fault)
        |=> (resp.fault == FLT_GENERAL_PROTECTION_FAULT && !resp.fault_code_enclave_bit);
  endproperty
  a_seg_first: assert property (p_seg_first) else $error("segment fault lost or outranked");

  property p_alter;
    @(posedge pclk) disable iff (!presetn)
      (req.valid && req.origin == ORIG_ORDINARY && meta.is_epc && ctrl_r[`EAC_CTRL_ALTER_EN] &&
       !req.seg_fault && !req.pg_fault) |=> resp.alter;
  endproperty
  a_alter: assert property (p_alter) else $error("outside hit on enclave memory not altered");

  property p_split;
    @(posedge pclk) disable iff (!presetn)
      (req.valid && direct && req.kind == ACC_READ && start_in && !end_in) |=> resp.split;
  endproperty
  a_split: assert property (p_split) else $error("straddling read not split");

  property p_apb_wait;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb answer not on second access cycle");
endmodule // enclave_access_checker

/* File: verif/core_model.sv */
`timescale 1ns/10ps
module core_model
  import enclave_access_checker_pkg::*;
#(
  parameter enclave_access_checker_pkg::fsgs_t APP = '0
)
(
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire enclave_access_checker_pkg::fsgs_t load_fsgs,
  input  wire logic                              load_valid,
  input  wire enclave_access_checker_pkg::fsgs_t frame_store,
  input  wire logic                              frame_store_valid,
  output enclave_access_checker_pkg::fsgs_t      cur_fsgs,
  output enclave_access_checker_pkg::fsgs_t      frame_fsgs
);
  // fs/gs as the core holds them; the core obeys every load the checker orders
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cur_fsgs <= APP;
    else if (load_valid)
      cur_fsgs <= load_fsgs;
  end

  // save frame memory, written only on an asynchronous leave
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      frame_fsgs <= '0;
    else if (frame_store_valid)
      frame_fsgs <= frame_store;
  end
endmodule // core_model

/* File: verif/test_enclave_access_checker.sv */
`timescale 1ns/10ps
module test_enclave_access_checker;
  import enclave_access_checker_pkg::*;
  localparam fsgs_t APP = {64'h1111_1111_1111_1111, 64'h2222_2222_2222_2222};
  localparam fsgs_t THREAD_CONTROL_STRUCTURE = {64'h3333_3333_3333_3333, 64'h4444_4444_4444_4444};
  localparam fault_kind_t GP = FLT_GENERAL_PROTECTION_FAULT;
  localparam fault_kind_t PF = FLT_PAGE_FAULT;
  localparam fault_kind_t NO = FLT_NONE;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, leave = 0, async_leave = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic        pready, pslverr, load_valid, frame_store_valid, enter_gp, in_enclave;
  access_req_t req = '0;
  page_meta_t  meta = '0, g;
  enter_req_t  enter = '0;
  check_resp_t resp;
  fsgs_t       cur_fsgs, frame_fsgs, load_fsgs, frame_store;
  fsgs_t       tcs_fsgs = THREAD_CONTROL_STRUCTURE;
  int          errors = 0, checks = 0, nflt = 0;

  enclave_access_checker u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .req, .meta, .resp, .enter, .leave, .async_leave, .cur_fsgs, .tcs_fsgs, .frame_fsgs, .load_fsgs,
    .load_valid, .frame_store, .frame_store_valid, .enter_gp, .in_enclave);
  core_model #(.APP(APP)) u_core (.pclk, .presetn, .load_fsgs, .load_valid, .frame_store, .frame_store_valid,
    .cur_fsgs, .frame_fsgs);

  // 125 MHz clock
  always #4 pclk = ~pclk;

  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // apb master: pready is read before the edge's updates land, so it is the sampled value
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (!pready);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, x);
    chk(e, xe);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  function automatic page_meta_t pm(input logic [1:0] oa, input page_type_t t, input logic [2:0] rwx,
                                    input logic [2:0] bpm);
    return '{1'b1, oa[1], oa[0], t, rwx[2], rwx[1], rwx[0], bpm[2], bpm[1], bpm[0]};
  endfunction

  // one access; i = {seg, pg, virt} in, x = {enclave bit, virt, split, alter} out
  task automatic acc(input origin_t o, input acc_kind_t k, input logic [31:0] a, input logic [3:0] s,
                     input page_meta_t m, input fault_kind_t f, input logic [2:0] i, input logic [3:0] x);
    @(posedge pclk);
    req <= '{1'b1, o, k, a, s, i[2], i[1], i[0]};
    meta <= m;
    @(posedge pclk);
    req.valid <= 1'b0;
    #1;
    chk({resp.valid, resp.fault, resp.fault_code_enclave_bit, resp.virt_exit, resp.split, resp.alter},
        {1'b1, f, x});
    if (f == GP)
      chk(resp.err_code, 16'h0000);
    if (f != NO)
      nflt++;
  endtask

  task automatic ent(input logic r, input logic [3:0] u, input logic [127:0] b, input logic gp, input fsgs_t ld);
    @(posedge pclk);
    enter <= '{1'b1, r, u, b};
    @(posedge pclk);
    enter.valid <= 1'b0;
    #1;
    chk({enter_gp, load_valid, in_enclave}, {gp, !gp, !gp});
    if (!gp)
      chk(load_fsgs, ld);
  endtask

  task automatic ext(input logic as, input fsgs_t fr);
    @(posedge pclk);
    leave <= !as; async_leave <= as;
    @(posedge pclk);
    leave <= 1'b0; async_leave <= 1'b0;
    #1;
    chk({load_valid, frame_store_valid, in_enclave}, {1'b1, as, 1'b0});
    chk(load_fsgs, APP);
    if (as)
      chk(frame_store, fr);
  endtask

  task automatic final_report();
    if (errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // a hang ends the run as a mismatch
  initial begin
    repeat (5000) @(posedge pclk);
    errors++;
    final_report();
  end

  // main sequence: range 0x1000..0x1fff, in-range page at 0x1100, outside at 0x3000
  initial begin
    page_type_t rt[4];
    rt = '{thread_control_page_type, trimmed_page_type, control_structure_page_type, version_array_page_type};
    g = pm(2'b11, regular_page_type, 3'b111, 3'b000);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(12'h000, 32'h0000_0003, 1'b0);
    rdchk(12'h004, 32'h0000_0000, 1'b0);
    rdchk(12'h014, 32'h0000_0000, 1'b1);
    wr(12'h004, 32'h0000_1000);
    wr(12'h008, 32'h0000_1FFF);
    rdchk(12'h008, 32'h0000_1FFF, 1'b0);
    ent(1'b0, 4'b0001, {96'h0, 32'h0000_0010}, 1'b1, THREAD_CONTROL_STRUCTURE);
    ent(1'b0, 4'b1110, {96'h0, 32'h0000_0010}, 1'b0, THREAD_CONTROL_STRUCTURE);
    acc(ORIG_ENCLAVE, ACC_FETCH, 32'h0000_3000, 0, g, GP, 0, 0);
    acc(ORIG_ENCLAVE, ACC_SS_LOAD, 32'h0000_3000, 0, pm(3, shadow_stack_first_page_type, 0, 0), GP, 0, 0);
    acc(ORIG_ENCLAVE, ACC_SS_STORE, 32'h0000_3000, 0, pm(3, shadow_stack_rest_page_type, 0, 0), GP, 0, 0);
    acc(ORIG_ENCLAVE, ACC_FETCH, 32'h0000_1FFE, 3, g, GP, 0, 0);
    acc(ORIG_ENCLAVE, ACC_READ, 32'h0000_1FFE, 3, g, NO, 0, 4'b0010);
    acc(ORIG_ENCLAVE, ACC_WRITE, 32'h0000_0FFE, 3, g, NO, 0, 4'b0010);
    acc(ORIG_ENCLAVE, ACC_READ, 32'h0000_1100, 0, pm(2, regular_page_type, 7, 0), PF, 0, 4'b1000);
    acc(ORIG_ENCLAVE, ACC_READ, 32'h0000_1100, 0, pm(1, regular_page_type, 7, 0), PF, 0, 4'b1000);
    acc(ORIG_ENCLAVE, ACC_WRITE, 32'h0000_1100, 0, pm(3, regular_page_type, 5, 0), PF, 0, 4'b1000);
    acc(ORIG_ENCLAVE, ACC_READ, 32'h0000_1100, 0, pm(3, regular_page_type, 3, 0), PF, 0, 4'b1000);
    acc(ORIG_ENCLAVE, ACC_FETCH, 32'h0000_1100, 0, pm(3, regular_page_type, 6, 0), PF, 0, 4'b1000);
    acc(ORIG_ENCLAVE, ACC_SS_LOAD, 32'h0000_1100, 0, g, PF, 0, 4'b1000);
    acc(ORIG_ENCLAVE, ACC_SS_STORE, 32'h0000_1100, 0, pm(3, shadow_stack_first_page_type, 0, 0), NO, 0, 0);
    acc(ORIG_ENCLAVE, ACC_WRITE, 32'h0000_1100, 0, pm(3, shadow_stack_rest_page_type, 7, 0), PF, 0, 4'b1000);
    foreach (rt[n])
      acc(ORIG_ENCLAVE, ACC_READ, 32'h0000_1100, 0, pm(3, rt[n], 7, 0), PF, 0, 4'b1000);
    for (int n = 0; n < 3; n++)
      acc(ORIG_ENCLAVE, ACC_READ, 32'h0000_1100, 0, pm(3, regular_page_type, 7, 3'(1 << n)), PF, 0, 4'b1000);
    acc(ORIG_ENCLAVE, ACC_READ, 32'h0000_1100, 0, pm(3, regular_page_type, 7, 4), GP, 3'b100, 0);
    acc(ORIG_IMPLICIT, ACC_READ, 32'h0000_1100, 0, pm(0, trimmed_page_type, 0, 7), NO, 3'b111, 0);
    acc(ORIG_EXPLICIT, ACC_READ, 32'h0000_3000, 0, g, PF, 3'b010, 0);
    acc(ORIG_EXPLICIT, ACC_READ, 32'h0000_3000, 0, g, NO, 3'b001, 4'b0100);
    ext(1'b0, THREAD_CONTROL_STRUCTURE);
    acc(ORIG_ORDINARY, ACC_READ, 32'h0000_1100, 0, g, NO, 0, 4'b0001);
    wr(12'h000, 32'h0000_0001);
    acc(ORIG_ORDINARY, ACC_READ, 32'h0000_1100, 0, g, NO, 0, 0);
    acc(ORIG_ORDINARY, ACC_WRITE, 32'h0000_3000, 0, g, GP, 3'b100, 0);
    ent(1'b0, 4'b1111, 128'h0, 1'b0, THREAD_CONTROL_STRUCTURE);
    ext(1'b1, THREAD_CONTROL_STRUCTURE);
    tcs_fsgs <= '0;
    ent(1'b1, 4'b1111, 128'h0, 1'b0, THREAD_CONTROL_STRUCTURE);
    ext(1'b0, THREAD_CONTROL_STRUCTURE);
    rdchk(12'h010, 32'(nflt), 1'b0);
    final_report();
  end
endmodule // test_enclave_access_checker
